// [rtl/mre_buf.sv]
/*
 * two-entry buffer for finished words, valid and ready on both sides.
 * assumes the drain side may hold out_ready low for any time.
 */
`timescale 1ns/1ps
module mre_buf (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic in_valid,
	output logic in_ready,
	input mre_pkg::mre_out_t in_data,
	output logic out_valid,
	input wire logic out_ready,
	output mre_pkg::mre_out_t out_data
);
	import mre_pkg::*;

	mre_out_t mem [2];
	mre_out_t next_head;
	logic wp, rp, next_wp, next_rp, push, pop;
	logic [1:0] cnt, next_cnt;

	always_comb begin
		push = in_valid && in_ready;
		pop = out_valid && out_ready;
		next_wp = wp ^ push;
		next_rp = rp ^ pop;
		next_cnt = cnt + {1'b0, push} - {1'b0, pop};
		// head held in its own register so the output never passes a mux
		next_head = (push && wp == next_rp) ? in_data : mem[next_rp];
	end

	// flags come from the next count so both stay honest in the same cycle
	always_ff @(posedge core_clk) begin
		if (srst) begin
			wp <= 1'b0;
			rp <= 1'b0;
			cnt <= 2'h0;
			in_ready <= 1'b1;
			out_valid <= 1'b0;
			out_data <= '0;
		end else begin
			wp <= next_wp;
			rp <= next_rp;
			cnt <= next_cnt;
			out_data <= next_head;
			in_ready <= (next_cnt != 2'h2);
			out_valid <= (next_cnt != 2'h0);
		end
		if (push) begin
			mem[wp] <= in_data;
		end
	end

endmodule : mre_buf

// [rtl/mre_div.sv]
/*
 * restoring divider, one quotient bit per clock.
 * assumes start only while idle; a zero divisor yields all ones.
 */
`timescale 1ns/1ps
module mre_div (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic start,
	input wire logic [31:0] num,
	input wire logic [15:0] den,
	output logic done,
	output logic [31:0] quo
);
	import mre_pkg::*;

	logic busy, next_busy, next_done;
	logic [5:0] cnt, next_cnt;
	logic [16:0] rem, next_rem, shifted;
	logic [31:0] next_quo;
	logic [15:0] dq, next_dq;

	always_comb begin
		next_busy = busy;
		next_done = 1'b0;
		next_cnt = cnt;
		next_rem = rem;
		next_quo = quo;
		next_dq = dq;
		shifted = {rem[15:0], quo[31]};
		if (!busy && start) begin
			next_busy = 1'b1;
			next_cnt = DIV_STEPS;
			next_rem = 17'h00000;
			next_quo = num;
			next_dq = den;
		end else if (busy) begin
			if (shifted >= {1'b0, dq}) begin
				next_rem = shifted - {1'b0, dq};
				next_quo = {quo[30:0], 1'b1};
			end else begin
				next_rem = shifted;
				next_quo = {quo[30:0], 1'b0};
			end
			next_cnt = cnt - 6'h01;
			if (cnt == 6'h01) begin
				next_busy = 1'b0;
				next_done = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			busy <= 1'b0;
			done <= 1'b0;
			cnt <= 6'h00;
			rem <= 17'h00000;
			quo <= 32'h00000000;
			dq <= 16'h0000;
		end else begin
			busy <= next_busy;
			done <= next_done;
			cnt <= next_cnt;
			rem <= next_rem;
			quo <= next_quo;
			dq <= next_dq;
		end
	end

endmodule : mre_div

// [rtl/mre_pkg.sv]
/*
 * constants, carriers and helper functions of the endian and register
 * remap data path.
 * assumes one core clock and configuration words presented by the slave core.
 */
package mre_pkg;

	// ----------------------------------------
	// byte order and function codes
	// ----------------------------------------
	localparam logic [15:0] BO_BIG = 16'h0000;
	localparam logic [15:0] BO_LITTLE = 16'h0001;
	localparam logic [15:0] BO_SPECIAL = 16'h0002;
	localparam logic [15:0] BO_RESET = BO_BIG;
	localparam logic [7:0] FC_READ_HOLD = 8'h03;
	localparam logic [7:0] FC_WRITE_ONE = 8'h06;
	localparam logic [7:0] FC_WRITE_MULTI = 8'h10;
	localparam logic [7:0] FC_RW_MULTI = 8'h17;
	localparam logic [7:0] FC_OPT_A = 8'h51;
	localparam logic [7:0] FC_OPT_B = 8'h52;
	localparam logic [7:0] FC_OPT_C = 8'h53;
	localparam logic [15:0] TRIP_FIRST = 16'h0012;
	localparam logic [15:0] TRIP_LAST = 16'h004E;

	// ----------------------------------------
	// mapping
	// ----------------------------------------
	localparam int MAP_ENTRIES = 10;
	localparam logic [15:0] MAP_ON = 16'h0001;
	localparam logic [15:0] REG_UNSET = 16'h0000;
	localparam logic [15:0] FMT_SIGNED = 16'h0001;
	localparam logic [15:0] SCALE_UNIT = 16'h03E8;
	localparam logic [7:0] EXC_NONE = 8'h00;
	localparam logic [7:0] EXC_MAP_CFG = 8'h31;
	localparam logic [7:0] EXC_MAP_HALF = 8'h32;
	localparam logic [5:0] DIV_STEPS = 6'h20;

	typedef struct packed {
		logic [15:0] ext_num;
		logic [15:0] fmt;
		logic [15:0] scale;
		logic [15:0] tgt;
		logic tgt_bad;
	} mre_entry_t;

	typedef struct packed {
		logic [15:0] byte_order;
		logic [15:0] map_en;
		mre_entry_t [MAP_ENTRIES-1:0] ent;
	} mre_cfg_t;

	typedef struct packed {
		logic [7:0] fc;
		logic opt_path;
		logic is_rsp;
		logic dlen;
		logic dbl_half;
		logic [15:0] reg_num;
		logic [31:0] data;
	} mre_req_t;

	typedef struct packed {
		logic [15:0] reg_num;
		logic [31:0] data;
		logic dlen;
		logic is_rsp;
		logic mapped;
		logic [7:0] exc;
	} mre_out_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_DIV = 2'b01,
		ST_PUSH = 2'b11
	} mre_state_t;

	// one swap serves both directions: every order is its own inverse
	function automatic logic [31:0] mre_reorder(input logic [31:0] d, input logic dlen,
		input logic [15:0] bo);
		logic [31:0] r;
		r = d;
		if (bo == BO_LITTLE) begin
			r = dlen ? {d[7:0], d[15:8], d[23:16], d[31:24]} : {d[31:16], d[7:0], d[15:8]};
		end else if (bo == BO_SPECIAL && dlen) begin
			r = {d[15:0], d[31:16]};
		end
		return r;
	endfunction : mre_reorder

	function automatic logic mre_fc_ordered(input logic [7:0] fc, input logic opt);
		logic hit;
		hit = (fc == FC_READ_HOLD) || (fc == FC_WRITE_ONE) || (fc == FC_WRITE_MULTI);
		if (opt) begin
			hit = hit || (fc == FC_OPT_A) || (fc == FC_OPT_B) || (fc == FC_OPT_C);
		end else begin
			hit = hit || (fc == FC_RW_MULTI);
		end
		return hit;
	endfunction : mre_fc_ordered

endpackage : mre_pkg

// [rtl/mre_remap.sv]
/*
 * data path of the slave: byte reordering of holding-register data and
 * remapping of external register numbers with scaling and format.
 * assumes the slave core splits frames into data words, computes the frame
 * check over what leaves here, and presents configuration during srst.
 */
// Contract
// RULE1: reorder only holding-register function codes 03h, 06h, 10h, 17h.
// RULE2: option path also reorders 03h, 06h, 10h, 51h, 52h, 53h.
// RULE3: only data bytes are reordered; header fields stay as received.
// RULE4: reads of registers 0012h to 004Eh always return big-endian data.
// RULE5: byte order setting 00 big, 01 little, 02 special.
// RULE6: byte order defaults to big endian, value 00.
// RULE7: single word: big and special high first, little low first.
// RULE8: double word: little fully reversed, special low word first.
// RULE9: frame check is computed over the reordered bytes as sent.
// RULE10: ten independent mapping entries.
// RULE11: matching external number redirects to internal register with conversion.
// RULE12: a mapping hides a real internal register at the same number.
// RULE13: mapping enable 00 off, 01 on.
// RULE14: external or internal number 0000h means entry unconfigured; code treats only external 0000h so, internal 0000h gives 31h.
// RULE15: entry format 00 unsigned word, 01 signed word.
// RULE16: mapped write stores external data times scale, 0.001 to 65.535.
// RULE17: mapped read returns internal data divided by scale.
// RULE18: double-length registers are refused as mapping targets.
// RULE19: exception 31h for missing target, bad target, or duplicate entries.
// RULE20: exception 32h on access to unmapped half of mapped double register.
// RULE21: mapping configuration is latched at reset only.
`timescale 1ns/1ps
module mre_remap (
	input wire logic core_clk,
	input wire logic srst,
	input mre_pkg::mre_cfg_t cfg,
	input wire logic req_valid,
	output logic req_ready,
	input mre_pkg::mre_req_t req,
	output logic out_valid,
	input wire logic out_ready,
	output mre_pkg::mre_out_t out_word,
	output logic cfg_fault
);
	import mre_pkg::*;

	// ----------------------------------------
	// configuration latch
	// ----------------------------------------
	mre_cfg_t cfg_q, next_cfg_q;
	logic [15:0] bo_eff;
	logic map_on;
	logic [MAP_ENTRIES-1:0] ent_used, ent_bad;
	logic next_cfg_fault;

	always_comb begin
		next_cfg_q = cfg_q;
		if (srst) begin
			next_cfg_q = cfg; // see RULE21
		end
	end

	always_ff @(posedge core_clk) begin
		cfg_q <= next_cfg_q;
	end

	// illegal settings fall back to the default order
	always_comb begin
		bo_eff = BO_RESET; // see RULE6
		if (cfg_q.byte_order == BO_LITTLE || cfg_q.byte_order == BO_SPECIAL) begin
			bo_eff = cfg_q.byte_order; // see RULE5
		end
		map_on = (cfg_q.map_en == MAP_ON); // see RULE13
	end

	always_comb begin
		next_cfg_fault = 1'b0;
		for (int i = 0; i < MAP_ENTRIES; i++) begin
			ent_used[i] = (cfg_q.ent[i].ext_num != REG_UNSET); // see RULE14
			ent_bad[i] = (cfg_q.ent[i].tgt == REG_UNSET) || cfg_q.ent[i].tgt_bad; // see RULE18
			for (int j = 0; j < MAP_ENTRIES; j++) begin
				if (j != i && cfg_q.ent[j].ext_num == cfg_q.ent[i].ext_num) begin
					ent_bad[i] = 1'b1; // see RULE19
				end
			end
			next_cfg_fault = next_cfg_fault || (ent_used[i] && ent_bad[i]);
		end
		next_cfg_fault = next_cfg_fault && map_on;
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			cfg_fault <= 1'b0;
		end else begin
			cfg_fault <= next_cfg_fault;
		end
	end

	// ----------------------------------------
	// lookup
	// ----------------------------------------
	logic hit, hit_bad, near_hit, ordered;
	mre_entry_t hit_ent;
	logic [31:0] ro_data;
	logic [15:0] mag_in;
	logic neg_in;

	always_comb begin
		hit = 1'b0;
		hit_bad = 1'b0;
		near_hit = 1'b0;
		hit_ent = cfg_q.ent[0];
		for (int i = 0; i < MAP_ENTRIES; i++) begin // see RULE10
			if (ent_used[i] && cfg_q.ent[i].ext_num == req.reg_num && !hit) begin
				hit = 1'b1; // see RULE12
				hit_bad = ent_bad[i];
				hit_ent = cfg_q.ent[i];
			end
			if (ent_used[i] && (cfg_q.ent[i].ext_num == req.reg_num + 16'h0001
				|| cfg_q.ent[i].ext_num == req.reg_num - 16'h0001)) begin
				near_hit = 1'b1;
			end
		end
		hit = hit && map_on;
		near_hit = near_hit && map_on && req.dbl_half;
		// trip history reads bypass the selected order
		ordered = mre_fc_ordered(req.fc, req.opt_path) // see RULE1, RULE2
			&& !(req.is_rsp && req.reg_num >= TRIP_FIRST && req.reg_num <= TRIP_LAST); // see RULE4
		// header fields never enter this path, only the data word
		ro_data = ordered ? mre_reorder(req.data, req.dlen, bo_eff) : req.data; // see RULE3, RULE7, RULE8
		// writes convert wire order first; responses convert after scaling
		mag_in = req.is_rsp ? req.data[15:0] : ro_data[15:0];
		neg_in = (hit_ent.fmt == FMT_SIGNED) && mag_in[15]; // see RULE15
		if (neg_in) begin
			mag_in = 16'h0000 - mag_in;
		end
	end

	// ----------------------------------------
	// sequencing
	// ----------------------------------------
	mre_state_t state, next_state;
	mre_out_t hold, next_hold;
	logic neg, next_neg, sgn, next_sgn, ord, next_ord;
	logic next_req_ready, div_start;
	logic [31:0] div_num, div_q, sat;
	logic [15:0] div_den, res;
	logic div_done, buf_ready;

	always_comb begin
		next_state = state;
		next_hold = hold;
		next_neg = neg;
		next_sgn = sgn;
		next_ord = ord;
		div_start = 1'b0;
		div_num = 32'h00000000;
		div_den = SCALE_UNIT;
		sat = div_q;
		res = div_q[15:0];
		case (state)
			ST_IDLE: begin
				if (req_valid && req_ready) begin
					next_hold.reg_num = req.reg_num;
					next_hold.data = ro_data; // see RULE9
					next_hold.dlen = req.dlen;
					next_hold.is_rsp = req.is_rsp;
					next_hold.mapped = 1'b0;
					next_hold.exc = EXC_NONE;
					next_neg = neg_in;
					next_sgn = (hit_ent.fmt == FMT_SIGNED);
					next_ord = ordered;
					next_state = ST_PUSH;
					if (hit && hit_bad) begin
						next_hold.exc = EXC_MAP_CFG; // see RULE19
					end else if (hit) begin
						next_hold.reg_num = hit_ent.tgt; // see RULE11
						next_hold.mapped = 1'b1;
						div_start = 1'b1;
						next_state = ST_DIV;
						if (req.is_rsp) begin
							div_num = {16'h0000, mag_in} * {16'h0000, SCALE_UNIT}; // see RULE17
							div_den = hit_ent.scale;
						end else begin
							div_num = {16'h0000, mag_in} * {16'h0000, hit_ent.scale}; // see RULE16
						end
					end else if (near_hit) begin
						next_hold.exc = EXC_MAP_HALF; // see RULE20
					end
				end
			end
			ST_DIV: begin
				if (div_done) begin
					// saturate rather than wrap when the scaled value overflows
					if (sgn) begin
						if (div_q > {16'h0000, 16'h7FFF} + {31'h00000000, neg}) begin
							sat = {16'h0000, 16'h7FFF} + {31'h00000000, neg};
						end
						res = neg ? 16'h0000 - sat[15:0] : sat[15:0];
					end else if (div_q[31:16] != 16'h0000) begin
						res = 16'hFFFF;
					end
					next_hold.data = {16'h0000, res};
					if (hold.is_rsp && ord) begin
						next_hold.data = mre_reorder({16'h0000, res}, 1'b0, bo_eff);
					end
					next_state = ST_PUSH;
				end
			end
			ST_PUSH: begin
				if (buf_ready) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		next_req_ready = (next_state == ST_IDLE);
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			state <= ST_IDLE;
			hold <= '0;
			neg <= 1'b0;
			sgn <= 1'b0;
			ord <= 1'b0;
			req_ready <= 1'b0;
		end else begin
			state <= next_state;
			hold <= next_hold;
			neg <= next_neg;
			sgn <= next_sgn;
			ord <= next_ord;
			req_ready <= next_req_ready;
		end
	end

	// ----------------------------------------
	// scaling and output buffer
	// ----------------------------------------
	// a shared serial divider trades 33 cycles per mapped word for area
	mre_div u_div (
		.core_clk(core_clk),
		.srst(srst),
		.start(div_start),
		.num(div_num),
		.den(div_den),
		.done(div_done),
		.quo(div_q)
	);

	mre_buf u_buf (
		.core_clk(core_clk),
		.srst(srst),
		.in_valid(state == ST_PUSH),
		.in_ready(buf_ready),
		.in_data(hold),
		.out_valid(out_valid),
		.out_ready(out_ready),
		.out_data(out_word)
	);

endmodule : mre_remap

// [sim/mre_drain.sv]
/* far side of mre_remap: a master that takes finished words and may stall.
   assumes out_word holds still until taken. */
`timescale 1ns/1ps
module mre_drain (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic hold,
	input wire logic out_valid,
	input mre_pkg::mre_out_t out_word,
	output logic out_ready
);
	import mre_pkg::*;
	mre_out_t q[$];
	// a slow master lowers ready; the word must wait, not vanish
	assign out_ready = !hold;
	always @(posedge core_clk) begin
		if (!srst && out_valid && out_ready) begin
			q.push_back(out_word);
		end
	end
endmodule : mre_drain

// [sim/mre_remap_props.sv]
/* assertions on the ports of mre_remap.
   assumes configuration is presented during srst; bound after the module. */
`timescale 1ns/1ps
module mre_remap_props (
	input wire logic core_clk,
	input wire logic srst,
	input mre_pkg::mre_cfg_t cfg,
	input wire logic req_valid,
	input wire logic req_ready,
	input mre_pkg::mre_req_t req,
	input wire logic out_valid,
	input wire logic out_ready,
	input mre_pkg::mre_out_t out_word,
	input wire logic cfg_fault
);
	import mre_pkg::*;
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	logic take;
	logic plain;
	logic trip;
	assign take = req_valid && req_ready;
	assign plain = req.opt_path ? !(req.fc inside {8'h03, 8'h06, 8'h10, 8'h51, 8'h52, 8'h53})
		: !(req.fc inside {8'h03, 8'h06, 8'h10, 8'h17});
	assign trip = req.is_rsp && (req.reg_num >= TRIP_FIRST) && (req.reg_num <= TRIP_LAST);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	// empty buffer at the take, so the head two edges on is this word
	sequence s_lone_take(c);
		take && !out_valid && c;
	endsequence
	sequence s_word;
		out_valid && !out_word.mapped && out_word.exc == EXC_NONE;
	endsequence
	// ----------------------------------------
	// properties
	// ----------------------------------------
	a_reset_quiet: assert property (disable iff (1'b0) srst |=> !req_ready && !out_valid)
		else $error("outputs active after reset edge");
	a_take_blocks: assert property (take |=> !req_ready)
		else $error("ready stayed high after a take");
	a_hold_word: assert property (out_valid && !out_ready |=> out_valid && $stable(out_word))
		else $error("word changed while stalled");
	a_no_early: assert property (s_lone_take(1'b1) |=> !out_valid)
		else $error("word appeared one edge after take");
	a_answer_bound: assert property (s_lone_take(1'b1) |-> ##[2:36] out_valid)
		else $error("no word within 36 edges");
	a_ready_back: assert property (s_lone_take(1'b1) |-> ##[2:36] req_ready)
		else $error("ready did not return");
	a_exc_codes: assert property (out_valid |-> out_word.exc inside {8'h00, 8'h31, 8'h32})
		else $error("unknown exception code");
	a_plain_data: assert property (s_lone_take(plain) ##2 s_word |->
		out_word.data[15:0] == $past(req.data[15:0], 2)) else $error("plain code reordered");
	a_trip_native: assert property (s_lone_take(trip) ##2 s_word |->
		out_word.data[15:0] == $past(req.data[15:0], 2)) else $error("trip data reordered");
	a_hdr_kept: assert property (s_lone_take(1'b1) ##2 s_word |->
		out_word.reg_num == $past(req.reg_num, 2)) else $error("header number changed");
endmodule : mre_remap_props
bind mre_remap mre_remap_props u_props (.core_clk(core_clk), .srst(srst), .cfg(cfg),
	.req_valid(req_valid), .req_ready(req_ready), .req(req), .out_valid(out_valid),
	.out_ready(out_ready), .out_word(out_word), .cfg_fault(cfg_fault));

// [sim/mre_remap_tb_top.sv]
/* self-checking bench of mre_remap: reorder table, remap, back-pressure.
   assumes mre_drain as far side and the bound checker. */
`timescale 1ns/1ps
module mre_remap_tb_top;
	import mre_pkg::*;
	logic core_clk, srst, req_valid, req_ready, out_valid, out_ready, cfg_fault, hold, ord;
	mre_cfg_t cfg;
	mre_req_t req;
	mre_out_t out_word, w;
	int n_errors, comparisons, k;
	logic [31:0] ex_d [3] = '{32'h01020304, 32'h04030201, 32'h03040102};
	logic [15:0] ex_s [3] = '{16'h0102, 16'h0201, 16'h0102};
	logic [7:0] fcs [8] = '{8'h03, 8'h06, 8'h10, 8'h17, 8'h51, 8'h52, 8'h53, 8'h04};
	logic [15:0] rns [4] = '{16'h0011, 16'h0012, 16'h004E, 16'h004F};
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	mre_remap DUT (.core_clk(core_clk), .srst(srst), .cfg(cfg), .req_valid(req_valid),
		.req_ready(req_ready), .req(req), .out_valid(out_valid), .out_ready(out_ready),
		.out_word(out_word), .cfg_fault(cfg_fault));
	mre_drain u_far (.core_clk(core_clk), .srst(srst), .hold(hold), .out_valid(out_valid),
		.out_word(out_word), .out_ready(out_ready));
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : final_report
	task automatic reboot;
		srst <= 1'b1;
		repeat (2) @(posedge core_clk);
		#1 chk("quiet", {29'h0, req_ready, out_valid, cfg_fault}, 32'h0);
		@(posedge core_clk);
		srst <= 1'b0;
		// first edge after srst falls loads cfg_fault before anyone reads it
		repeat (2) @(posedge core_clk);
	endtask : reboot
	// f is opt_path, is_rsp, dlen, dbl_half
	task automatic send(input logic [7:0] fc, input logic [3:0] f, input logic [15:0] rn,
		input logic [31:0] d);
		@(posedge core_clk);
		req <= '{fc, f[3], f[2], f[1], f[0], rn, d};
		req_valid <= 1'b1;
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (!req_ready && k < 60);
		req_valid <= 1'b0;
		if (k == 60) begin
			n_errors++;
			final_report();
		end
	endtask : send
	// fl is mapped flag then exception code; data of an exception is not defined
	task automatic get(input logic dl, input logic [15:0] rn, input logic [31:0] d,
		input logic [8:0] fl);
		k = 0;
		while (u_far.q.size() == 0 && k < 80) begin
			@(posedge core_clk);
			k++;
		end
		if (k == 80) begin
			n_errors++;
			final_report();
		end
		w = u_far.q.pop_front();
		chk("exc", {24'h0, w.exc}, {24'h0, fl[7:0]});
		chk("dlen", {31'h0, w.dlen}, {31'h0, dl});
		if (fl[7:0] == EXC_NONE) begin
			chk("mapped", {31'h0, w.mapped}, {31'h0, fl[8]});
			chk("reg_num", {16'h0, w.reg_num}, {16'h0, rn});
			chk("data", dl ? w.data : {16'h0, w.data[15:0]}, dl ? d : {16'h0, d[15:0]});
		end
	endtask : get
	task automatic xfer(input logic [7:0] fc, input logic [3:0] f, input logic [15:0] rn,
		input logic [31:0] d, input logic [15:0] ern, input logic [31:0] ed, input logic [8:0] fl);
		send(fc, f, rn, d);
		get(f[1], ern, ed, fl);
	endtask : xfer
	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		srst = 1'b1;
		req_valid = 1'b0;
		req = '0;
		cfg = '0;
		hold = 1'b0;
		n_errors = 0;
		comparisons = 0;
		for (int b = 0; b < 3; b++) begin
			cfg.byte_order <= 16'(b);
			reboot();
			xfer(8'h06, 4'h0, 16'h1F34, 32'h0102, 16'h1F34, {16'h0, ex_s[b]}, 9'h0);
			for (int i = 0; i < 16; i++) begin
				// option path drops 17h and adds 51h to 53h
				ord = i[3] ? (i[2:0] != 3 && i[2:0] != 7) : (i[2:0] < 4);
				xfer(fcs[i[2:0]], {i[3], 3'b010}, 16'h1F35, ex_d[0], 16'h1F35,
					ord ? ex_d[b] : ex_d[0], 9'h0);
			end
			for (int j = 0; j < 4; j++) begin
				xfer(8'h03, 4'h6, rns[j], ex_d[0], rns[j],
					(j == 1 || j == 2) ? ex_d[0] : ex_d[b], 9'h0);
			end
			$display("byte order %0d done", b);
		end
		cfg.byte_order <= BO_BIG;
		cfg.map_en <= MAP_ON;
		cfg.ent[0] <= '{16'h4005, 16'h0000, 16'h07D0, 16'h120F, 1'b0};
		cfg.ent[1] <= '{16'h4010, 16'h0000, SCALE_UNIT, REG_UNSET, 1'b0};
		cfg.ent[2] <= '{16'h4020, FMT_SIGNED, 16'h07D0, 16'h1300, 1'b0};
		cfg.ent[3] <= '{16'h1103, 16'h0000, SCALE_UNIT, 16'h1107, 1'b0};
		cfg.ent[4] <= '{16'h1F35, 16'h0000, SCALE_UNIT, 16'h1F36, 1'b0};
		cfg.ent[5] <= '{16'h4030, 16'h0000, SCALE_UNIT, 16'h1F33, 1'b1};
		cfg.ent[9] <= '{16'h4090, 16'h0000, SCALE_UNIT, 16'h1400, 1'b0};
		reboot();
		chk("fault", {31'h0, cfg_fault}, 32'h1);
		xfer(8'h06, 4'h0, 16'h4005, 32'h03E8, 16'h120F, 32'h07D0, 9'h100);
		xfer(8'h03, 4'h4, 16'h4005, 32'h07D0, 16'h120F, 32'h03E8, 9'h100);
		xfer(8'h06, 4'h0, 16'h4005, 32'hFFFF, 16'h120F, 32'hFFFF, 9'h100);
		xfer(8'h06, 4'h0, 16'h4020, 32'hFFF6, 16'h1300, 32'hFFEC, 9'h100);
		xfer(8'h03, 4'h4, 16'h4020, 32'hFFEC, 16'h1300, 32'hFFF6, 9'h100);
		xfer(8'h06, 4'h0, 16'h1F35, 32'h0007, 16'h1F36, 32'h0007, 9'h100);
		xfer(8'h06, 4'h0, 16'h4090, 32'h0005, 16'h1400, 32'h0005, 9'h100);
		xfer(8'h06, 4'h0, 16'h4010, 32'h0001, 16'h0, 32'h0, {1'b0, EXC_MAP_CFG});
		xfer(8'h06, 4'h0, 16'h4030, 32'h0001, 16'h0, 32'h0, {1'b0, EXC_MAP_CFG});
		xfer(8'h03, 4'h5, 16'h1104, 32'h0001, 16'h0, 32'h0, {1'b0, EXC_MAP_HALF});
		$display("mapping done");
		cfg.map_en <= 16'h0000;
		reboot();
		chk("fault", {31'h0, cfg_fault}, 32'h0);
		// a change outside reset must not reach the mapping
		cfg.map_en <= MAP_ON;
		xfer(8'h06, 4'h0, 16'h4005, 32'h03E8, 16'h4005, 32'h03E8, 9'h0);
		hold <= 1'b1;
		for (int i = 0; i < 3; i++) send(8'h04, 4'h0, 16'h0100 + 16'(i), 32'(i));
		repeat (4) @(posedge core_clk);
		chk("stall", {30'h0, req_ready, out_valid}, 32'h1);
		hold <= 1'b0;
		for (int i = 0; i < 3; i++) get(1'b0, 16'h0100 + 16'(i), 32'(i), 9'h0);
		$display("back-pressure done");
		final_report();
	end
endmodule : mre_remap_tb_top
